//--- dv/setpoint_ramp_soak_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "srs_regs.svh"
module setpoint_ramp_soak_sequencer_bench;
	localparam logic [32:0] ALL = 33'h1FFFFFFFF, ERR = 33'h100000000, NO = 33'h000000000;
	localparam logic [31:0] CFG = 32'h000A8021; // seg 1..2, end hold, rewind, contact hold
	localparam logic [31:0] CFG2 = 32'h00050021; // seg 1..2, end disabled, failsafe, start at pv
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic close_req = 1'b0, pready, pslverr, ext_hold_pin, running_ind, hold_ind, mfe;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, sp;
	logic [15:0] working_sp, held, mt;
	srs_pkg::srs_view_t view;
	logic [32:0] notes[$], masks[$]; // expected {error, data} and care bits
	int error_cnt = 0, checked = 0, seed = 83404, n;
	srs_sequencer #(.MINUTE_CYC(50), .FLASH_CYC(4)) srs_sequencer_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_hold_pin(ext_hold_pin), .running_ind(running_ind), .hold_ind(hold_ind),
		.manual_failsafe_end(mfe), .working_sp(working_sp), .view(view));
	srs_contact srs_contact_inst (.pclk(pclk), .close_req(close_req), .ext_hold_pin(ext_hold_pin));
	// 125 MHz tick
	initial begin
		forever #4 pclk = ~pclk;
	end
	// value compare and report
	task automatic cmp_val(string what, logic [32:0] e, logic [32:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask
	// bus answer compare, masked
	task automatic cmp_bus(logic [32:0] e, logic [32:0] m);
		cmp_val("bus", e & m, {pslverr, prdata} & m);
	endtask
	// one apb transfer, expectation noted first
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] e, logic [32:0] m);
		notes.push_back(e);
		masks.push_back(m);
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			error_cnt++;
			give_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// checks every bus answer as it appears
	always @(posedge pclk) begin
		if (psel && penable && pready) cmp_bus(notes.pop_front(), masks.pop_front());
	end
	task automatic give_verdict;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (3000) @(posedge pclk);
		error_cnt++;
		give_verdict();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `SRS_CFG_OFF, 0, {1'b0, `SRS_CFG_RESET}, ALL);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h1, 33'h7);
		apb(1'b0, 12'h020, 0, ERR, ALL);
		$display("test reset done");
		sp = $random(seed);
		apb(1'b1, `SRS_SPNOW_OFF, {16'h0000, sp[15:0]}, NO, ERR);
		apb(1'b0, `SRS_SPNOW_OFF, 0, {17'h00000, sp[15:0]}, ALL);
		apb(1'b1, `SRS_SEGT_OFF, 32'h3, NO, ERR);
		apb(1'b1, `SRS_SEGT_OFF + 12'h004, 32'h3, NO, ERR);
		apb(1'b1, `SRS_CFG_OFF, CFG, NO, ERR);
		apb(1'b1, `SRS_CTRL_OFF, 32'h1, NO, ERR);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h2, 33'h7);
		cmp_val("running", 33'h1, {32'h0, running_ind});
		apb(1'b1, `SRS_CFG_OFF, 32'h0, ERR, ERR);
		apb(1'b0, `SRS_CFG_OFF, 0, {1'b0, CFG}, ALL);
		$display("test run done");
		repeat (160) @(posedge pclk);
		cmp_val("segment", 33'h2, {29'h0, view.segment});
		close_req <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h1, 33'h7);
		apb(1'b1, `SRS_CTRL_OFF, 32'h1, NO, ERR);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h2, 33'h7);
		close_req <= 1'b0;
		repeat (8) @(posedge pclk);
		close_req <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h1, 33'h7);
		close_req <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h2, 33'h7);
		$display("test contact done");
		apb(1'b1, `SRS_CTRL_OFF, 32'h2, NO, ERR);
		held = working_sp;
		mt = {2'b00, view.hours, view.minutes};
		n = 0;
		repeat (60) begin
			@(posedge pclk);
			n += hold_ind;
		end
		cmp_val("flash", 33'h1, {32'h0, n > 0 && n < 60});
		cmp_val("setpoint", {17'h0, held}, {17'h0, working_sp});
		cmp_val("time", {17'h0, mt}, {19'h0, view.hours, view.minutes});
		apb(1'b1, `SRS_CTRL_OFF, 32'h4, NO, ERR);
		@(posedge pclk);
		cmp_val("segment", 33'h1, {29'h0, view.segment});
		$display("test hold done");
		apb(1'b1, `SRS_CTRL_OFF, 32'h1, NO, ERR);
		repeat (340) @(posedge pclk);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h1, 33'h7);
		cmp_val("end", 33'h0, {31'h0, running_ind, mfe});
		$display("test end done");
		apb(1'b1, `SRS_PV_OFF, {16'h0000, sp[31:16]}, NO, ERR);
		apb(1'b1, `SRS_CFG_OFF, CFG2, NO, ERR);
		apb(1'b1, `SRS_CTRL_OFF, 32'h1, NO, ERR);
		@(posedge pclk);
		cmp_val("pv start", {17'h0, sp[31:16]}, {17'h0, working_sp});
		repeat (340) @(posedge pclk);
		apb(1'b0, `SRS_STAT_OFF, 0, 33'h4, 33'h7);
		cmp_val("end", 33'h1, {31'h0, running_ind, mfe});
		$display("test failsafe done");
		give_verdict();
	end
endmodule // setpoint_ramp_soak_sequencer_bench
`default_nettype wire

//--- dv/srs_contact.sv
`timescale 1ns/1ps
`default_nettype none
// dry contact with pull-down: pin high only while closed
module srs_contact (
	input wire logic pclk,
	input wire logic close_req,
	output logic ext_hold_pin
);
	// contact follows the operator one tick late
	always_ff @(posedge pclk) begin
		ext_hold_pin <= close_req;
	end
endmodule // srs_contact
`default_nettype wire

//--- dv/srs_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the sequencer pins only
module srs_sequencer_asserts #(
	parameter int unsigned FLASH_CYC = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_hold_pin,
	input wire logic running_ind,
	input wire logic hold_ind,
	input wire logic manual_failsafe_end,
	input wire logic [15:0] working_sp,
	input wire srs_pkg::srs_view_t view
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a completed bus access
	sequence s_acc; psel && penable && pready; endsequence
	// holding with no bus traffic now or just before
	sequence s_idle; !running_ind && !psel && !$past(psel); endsequence
	property p_refuse; s_acc ##0 (pwrite && paddr == 12'h004 && running_ind) |-> pslverr; endproperty
	a_refuse: assert property (p_refuse) else $error("config write taken while running");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error flag outside access");
	property p_flash; $rose(hold_ind) |-> ##[1:6] !hold_ind; endproperty
	a_flash: assert property (p_flash) else $error("hold flash stuck on");
	property p_dark; running_ind [*2] |-> !hold_ind; endproperty
	a_dark: assert property (p_dark) else $error("hold shown while running");
	property p_freeze; s_idle |=> $stable(working_sp) || running_ind; endproperty
	a_freeze: assert property (p_freeze) else $error("setpoint moved in hold");
	property p_time; s_idle |=> $stable({view.hours, view.minutes}) || running_ind; endproperty
	a_time: assert property (p_time) else $error("segment time moved in hold");
	property p_seg; $past(presetn, 2) |-> view.segment inside {[4'h1:4'hC]} && view.minutes < 6'h3C;
	endproperty
	a_seg: assert property (p_seg) else $error("segment view out of range");
	property p_cyc; $past(presetn, 2) |-> view.cycles_left <= 7'h63; endproperty
	a_cyc: assert property (p_cyc) else $error("cycle count out of range");
	property p_fsafe; running_ind |-> !manual_failsafe_end; endproperty
	a_fsafe: assert property (p_fsafe) else $error("failsafe end while running");
endmodule // srs_sequencer_asserts
bind srs_sequencer srs_sequencer_asserts #(.FLASH_CYC(FLASH_CYC)) srs_sequencer_asserts_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_hold_pin(ext_hold_pin), .running_ind(running_ind), .hold_ind(hold_ind),
	.manual_failsafe_end(manual_failsafe_end), .working_sp(working_sp), .view(view));
`default_nettype wire

//--- logic/srs_pkg.sv
package srs_pkg;
	// program run states, one-hot
	typedef enum logic [2:0] {
		SRS_HOLD = 3'b001,
		SRS_RUN = 3'b010,
		SRS_DIS = 3'b100
	} srs_state_t;
	// display-facing view of the sequencer
	typedef struct packed {
		logic [3:0] segment;
		logic [7:0] hours;
		logic [5:0] minutes;
		logic [6:0] cycles_left;
	} srs_view_t;
endpackage

//--- logic/srs_regs.svh
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
// register byte offsets
`define SRS_CTRL_OFF 12'h000
`define SRS_CFG_OFF 12'h004
`define SRS_STAT_OFF 12'h008
`define SRS_SPNOW_OFF 12'h00C
`define SRS_PV_OFF 12'h010
`define SRS_SEGT_OFF 12'h040
// command bits in the control word (write one to act)
`define SRS_CMD_RUN 0
`define SRS_CMD_HOLD 1
`define SRS_CMD_REWIND 2
// configuration field positions
`define SRS_CFG_FIRST_LSB 0
`define SRS_CFG_LAST_LSB 4
`define SRS_CFG_RECYC_LSB 8
`define SRS_CFG_END_HOLD 15
`define SRS_CFG_FAILSAFE 16
`define SRS_CFG_REWIND_EN 17
`define SRS_CFG_PVSTART 18
`define SRS_CFG_DI_HOLD 19
// reset values
`define SRS_CFG_RESET 32'h00000B00
`define SRS_SP_RESET 16'h0000
// timing: one minute of program time, and the hold flash half period
`define SRS_MINUTE_S 60
`define SRS_CLK_HZ 125000000
// one minute of cycles needs 33 bits at this clock, so work it out in 64 bits
`define SRS_MINUTE_CYC (64'(`SRS_MINUTE_S) * 64'(`SRS_CLK_HZ))
`define SRS_FLASH_MS 500
`define SRS_FLASH_CYC (`SRS_FLASH_MS * (`SRS_CLK_HZ / 1000))
`endif

//--- logic/srs_sequencer.sv
// What this block does
// - parameters other than the process value writable only while program is not running (hold or disabled)
// - hold indication flashes while holding
// - run key starts program, shows running
// - hold key freezes setpoint and time
// - assigned contact closure forces hold while running
// - keypad requests override the contact
// - contact release resumes running
// - rewind returns to first segment
// - show segment 1-12 and time left
// - keep cycles left, 0 to 99
// - after last segment, hold or disable
// - end at last setpoint or failsafe manual
// - optional first start captures process value
// - power-up holds at program start, setpoint reset to zero
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "srs_regs.svh"
module srs_sequencer #(
	parameter longint unsigned MINUTE_CYC = `SRS_MINUTE_CYC,
	parameter int unsigned FLASH_CYC = `SRS_FLASH_CYC,
	parameter int unsigned NSEG = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_hold_pin,
	output logic running_ind,
	output logic hold_ind,
	output logic manual_failsafe_end,
	output logic [15:0] working_sp,
	output srs_pkg::srs_view_t view
);
	// two-stage synchroniser on the dry contact
	logic ext_s1_reg;
	logic ext_s2_reg;
	logic ext_prev_reg;
	// program parameters
	logic [31:0] cfg_reg;
	logic [15:0] seg_time_reg [NSEG];
	logic [15:0] local_sp_reg;
	logic [15:0] pv_reg;
	logic [15:0] saved_sp_reg;
	logic started_reg;
	// sequencer state
	srs_pkg::srs_state_t state_reg;
	srs_pkg::srs_state_t state_next;
	logic [3:0] seg_reg;
	logic [15:0] left_reg;
	logic [6:0] cyc_reg;
	logic [32:0] tick_reg; // wide enough for a full minute
	logic [31:0] flash_reg;
	logic flash_reg_on;
	logic failsafe_reg;
	// apb decode
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_ctrl = paddr == `SRS_CTRL_OFF;
	wire hit_cfg = paddr == `SRS_CFG_OFF;
	wire hit_stat = paddr == `SRS_STAT_OFF;
	wire hit_sp = paddr == `SRS_SPNOW_OFF;
	wire hit_pv = paddr == `SRS_PV_OFF;
	wire hit_segt = paddr >= `SRS_SEGT_OFF && paddr < 12'(`SRS_SEGT_OFF + 4 * NSEG)
		&& paddr[1:0] == 2'h0;
	wire [3:0] segt_idx = 4'((paddr - `SRS_SEGT_OFF) >> 2);
	wire mapped = hit_ctrl | hit_cfg | hit_stat | hit_sp | hit_pv | hit_segt;
	wire holding = state_reg != srs_pkg::SRS_RUN;
	// parameter writes refused while running
	wire par_ok = holding;
	wire cmd_run = wr & hit_ctrl & pwdata[`SRS_CMD_RUN];
	wire cmd_hold = wr & hit_ctrl & pwdata[`SRS_CMD_HOLD];
	wire cmd_rew = wr & hit_ctrl & pwdata[`SRS_CMD_REWIND] & cfg_reg[`SRS_CFG_REWIND_EN];
	// refusal seen in setup so pslverr lines up with pready
	wire bad_wr_setup = pwrite & (hit_cfg | hit_segt | hit_sp) & ~par_ok;
	// configuration fields
	wire [3:0] first_segment = cfg_reg[`SRS_CFG_FIRST_LSB +: 4];
	wire [3:0] last_segment = cfg_reg[`SRS_CFG_LAST_LSB +: 4];
	wire [6:0] recycle_count = cfg_reg[`SRS_CFG_RECYC_LSB +: 7];
	wire end_hold = cfg_reg[`SRS_CFG_END_HOLD];
	wire di_hold = cfg_reg[`SRS_CFG_DI_HOLD];
	// contact edges
	wire ext_close = ext_s2_reg & ~ext_prev_reg & di_hold;
	wire ext_open = ~ext_s2_reg & ext_prev_reg & di_hold;
	// minute tick only while running
	wire minute = state_reg == srs_pkg::SRS_RUN && tick_reg == 33'(MINUTE_CYC - 1);
	wire seg_done = minute && left_reg <= 16'h0001;
	wire last_done = seg_done && seg_reg == last_segment && cyc_reg == 7'h00;
	wire [15:0] first_time = seg_time_reg[first_segment - 4'h1];
	// next state; keypad checked first so it wins over the contact
	always_comb begin
		state_next = state_reg;
		if (cmd_hold && state_reg == srs_pkg::SRS_RUN) begin
			state_next = srs_pkg::SRS_HOLD;
		end else if (cmd_run && state_reg == srs_pkg::SRS_HOLD) begin
			state_next = srs_pkg::SRS_RUN;
		end else if (cmd_run || cmd_hold) begin
			state_next = state_reg;
		end else if (last_done) begin
			state_next = end_hold ? srs_pkg::SRS_HOLD : srs_pkg::SRS_DIS;
		end else if (ext_close && state_reg == srs_pkg::SRS_RUN) begin
			state_next = srs_pkg::SRS_HOLD;
		end else if (ext_open && state_reg == srs_pkg::SRS_HOLD) begin
			state_next = srs_pkg::SRS_RUN;
		end
	end
	// contact synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_hold_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_prev_reg <= ext_s2_reg;
		end
	end
	// configuration and process value writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `SRS_CFG_RESET;
			pv_reg <= `SRS_SP_RESET;
		end else begin
			if (wr && hit_cfg && par_ok) begin
				cfg_reg <= pwdata;
			end
			if (wr && hit_pv) begin
				pv_reg <= pwdata[15:0];
			end
		end
	end
	// segment times table, minutes per segment
	always_ff @(posedge pclk) begin
		if (wr && hit_segt && par_ok) begin
			seg_time_reg[segt_idx] <= pwdata[15:0];
		end
	end
	// state register; reset lands in hold at program start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= srs_pkg::SRS_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end
	// minute prescaler, cleared while not running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 33'h000000000;
		end else if (state_reg != srs_pkg::SRS_RUN || minute || cmd_rew) begin
			tick_reg <= 33'h000000000;
		end else begin
			tick_reg <= tick_reg + 33'h000000001;
		end
	end
	// segment, time left and cycles left
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_reg <= 4'h1;
			left_reg <= 16'h0000;
			cyc_reg <= 7'h00;
			started_reg <= 1'b0;
		end else if (cmd_rew || (!started_reg && state_next == srs_pkg::SRS_RUN)) begin
			seg_reg <= first_segment;
			left_reg <= first_time;
			cyc_reg <= recycle_count > 7'd99 ? 7'd99 : recycle_count;
			started_reg <= !cmd_rew;
		end else if (seg_done && !last_done) begin
			if (seg_reg == last_segment) begin
				seg_reg <= first_segment;
				left_reg <= first_time;
				cyc_reg <= cyc_reg - 7'h01;
			end else begin
				seg_reg <= seg_reg + 4'h1;
				left_reg <= seg_time_reg[seg_reg];
			end
		end else if (last_done) begin
			left_reg <= 16'h0000;
			started_reg <= 1'b0;
		end else if (minute) begin
			left_reg <= left_reg - 16'h0001;
		end
	end
	// working setpoint: held when not running, captured on first start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_sp_reg <= `SRS_SP_RESET;
			saved_sp_reg <= `SRS_SP_RESET;
			failsafe_reg <= 1'b0;
		end else begin
			if (wr && hit_sp && par_ok) begin
				local_sp_reg <= pwdata[15:0];
				saved_sp_reg <= pwdata[15:0];
			end else if (!started_reg && state_next == srs_pkg::SRS_RUN) begin
				saved_sp_reg <= local_sp_reg;
				if (cfg_reg[`SRS_CFG_PVSTART]) begin
					local_sp_reg <= pv_reg;
				end
			end else if (cmd_rew) begin
				local_sp_reg <= saved_sp_reg;
			end
			if (last_done) begin
				failsafe_reg <= cfg_reg[`SRS_CFG_FAILSAFE];
			end else if (state_next == srs_pkg::SRS_RUN) begin
				failsafe_reg <= 1'b0;
			end
		end
	end
	// hold flash timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_reg <= 32'h00000000;
			flash_reg_on <= 1'b0;
		end else if (state_reg != srs_pkg::SRS_HOLD) begin
			flash_reg <= 32'h00000000;
			flash_reg_on <= 1'b0;
		end else if (flash_reg == 32'(FLASH_CYC - 1)) begin
			flash_reg <= 32'h00000000;
			flash_reg_on <= ~flash_reg_on;
		end else begin
			flash_reg <= flash_reg + 32'h00000001;
		end
	end
	// display outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_ind <= 1'b0;
			hold_ind <= 1'b0;
			manual_failsafe_end <= 1'b0;
			working_sp <= `SRS_SP_RESET;
			view <= '0;
		end else begin
			running_ind <= state_reg == srs_pkg::SRS_RUN;
			hold_ind <= flash_reg_on;
			manual_failsafe_end <= failsafe_reg;
			working_sp <= local_sp_reg;
			view.segment <= seg_reg;
			view.hours <= 8'(left_reg / 16'd60);
			view.minutes <= 6'(left_reg % 16'd60);
			view.cycles_left <= cyc_reg;
		end
	end
	// apb read data and answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (~mapped | bad_wr_setup);
			if (hit_cfg) prdata <= cfg_reg;
			else if (hit_stat) prdata <= {22'h0, cyc_reg, state_reg};
			else if (hit_sp) prdata <= {16'h0, local_sp_reg};
			else if (hit_pv) prdata <= {16'h0, pv_reg};
			else if (hit_segt) prdata <= {16'h0, seg_time_reg[segt_idx]};
			else prdata <= 32'h00000000;
		end
	end
endmodule // srs_sequencer
`default_nettype wire
